// ==== verilog/signed_dec_mul_div_unit.sv ====
// Operation
// - 16-bit decrement subtracts one, wraps negative limit to positive.
// - 32-bit decrement subtracts one, wrapping across the 32-bit range.
// - Pulse variant executes once, on the enable's off-to-on edge.
// - Multiply treats both operands as signed two's complement.
// - 16-bit multiply writes one word; b15 is the sign.
// - 32-bit multiply writes two words, high half in next word.
// - 16-bit product overflow sets carry, stores low 16 bits.
// - 32-bit product overflow sets carry, stores low 32 bits.
// - Divide stores quotient and remainder in the destination area.
// - Most significant bit of operands and results is the sign.
// - 16-bit divide: quotient at destination, remainder next word.
// - 32-bit divide: quotient pair, high half in second word.
// - Zero divisor skips, sets error flag, loads divide-by-zero code.
// - Operand area past device range skips, sets error, range code.
`timescale 1ns/100ps
`include "arith_unit_params.svh"
module signed_dec_mul_div_unit
  import arith_unit_pkg::*;
#(
  parameter logic [`ADDR_W-1:0] LAST_ADDR = `ADDR_LAST
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Operation request
  input wire logic enable,
  input wire logic pulseMode,
  input wire op_t opSel,
  input wire logic [31:0] srcA,
  input wire logic [31:0] srcB,
  input wire logic [`ADDR_W-1:0] destAddr,
  // Result words and write strobe (word 0 is at destAddr)
  output logic [`WORD_W-1:0] resWord0_q,
  output logic [`WORD_W-1:0] resWord1_q,
  output logic [`WORD_W-1:0] resWord2_q,
  output logic [`WORD_W-1:0] resWord3_q,
  output logic [2:0] resCount_q,
  output logic resWrite_q,
  // Flags
  output logic carry_flag,
  output logic operation_error_flag,
  output logic [15:0] error_code_reg
);
  logic enableLast_q;
  logic fire;
  logic is32;
  logic isDiv;
  logic isMul;
  logic [2:0] words;
  logic [`ADDR_W:0] lastUsed;
  logic rangeErr;
  logic zeroErr;
  logic signed [31:0] divA;
  logic signed [31:0] divB;
  logic signed [31:0] quot;
  logic signed [31:0] rem;
  logic signed [31:0] prod16;
  logic signed [63:0] prod32;
  logic ovf;
  logic [63:0] resAll;

  // Previous enable, used for the pulse edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enableLast_q <= 1'b0;
    end else begin
      enableLast_q <= enable;
    end
  end

  // Level mode runs every enabled cycle; pulse mode on rising edge only
  assign fire = pulseMode ? (enable && !enableLast_q) : enable;

  assign is32 = (opSel == decrement_op_32) || (opSel == multiply_op_32) ||
                (opSel == divide_op_32);
  assign isDiv = (opSel == divide_op_16) || (opSel == divide_op_32);
  assign isMul = (opSel == multiply_op_16) || (opSel == multiply_op_32);

  // Words written: divide doubles the area for the remainder
  always_comb begin
    if (isDiv) begin
      words = is32 ? 3'd4 : 3'd2;
    end else begin
      words = is32 ? 3'd2 : 3'd1;
    end
  end

  // Range check on the whole destination area, no address wrap allowed
  assign lastUsed = {1'b0, destAddr} + {{(`ADDR_W-2){1'b0}}, words} -
                    {{`ADDR_W{1'b0}}, 1'b1};
  assign rangeErr = lastUsed > {1'b0, LAST_ADDR};
  assign zeroErr = isDiv && (is32 ? (srcB == 32'h0000_0000)
                                  : (srcB[15:0] == 16'h0000));

  // Sign-extend 16-bit operands so the MSB acts as sign
  assign divA = is32 ? srcA : {{16{srcA[15]}}, srcA[15:0]};
  assign divB = is32 ? srcB : {{16{srcB[15]}}, srcB[15:0]};

  signed_divider #(
    .W(32)
  ) divUnit (
    .dividend(divA),
    .divisor(divB),
    .quotient(quot),
    .remainder(rem)
  );

  // Full-width signed products
  assign prod16 = $signed(srcA[15:0]) * $signed(srcB[15:0]);
  assign prod32 = $signed(srcA) * $signed(srcB);

  // Overflow when the product does not fit the signed result width
  always_comb begin
    if (opSel == multiply_op_16) begin
      ovf = prod16 != {{16{prod16[15]}}, prod16[15:0]};
    end else if (opSel == multiply_op_32) begin
      ovf = prod32 != {{32{prod32[31]}}, prod32[31:0]};
    end else begin
      ovf = 1'b0;
    end
  end

  // Result packing, word 0 lowest
  always_comb begin
    case (opSel)
      decrement_op: begin
        resAll = {48'h0, srcA[15:0] - 16'h0001};
      end
      decrement_op_32: begin
        resAll = {32'h0, srcA - 32'h0000_0001};
      end
      multiply_op_16: begin
        resAll = {48'h0, prod16[15:0]};
      end
      multiply_op_32: begin
        resAll = {32'h0, prod32[31:0]};
      end
      divide_op_16: begin
        resAll = {32'h0, rem[15:0], quot[15:0]};
      end
      divide_op_32: begin
        resAll = {rem, quot};
      end
      default: begin
        resAll = 64'h0;
      end
    endcase
  end

  // Result words and strobe; errors suppress the write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resWord0_q <= 16'h0000;
      resWord1_q <= 16'h0000;
      resWord2_q <= 16'h0000;
      resWord3_q <= 16'h0000;
      resCount_q <= 3'd0;
      resWrite_q <= 1'b0;
    end else begin
      resWrite_q <= fire && !rangeErr && !zeroErr;
      if (fire && !rangeErr && !zeroErr) begin
        resWord0_q <= resAll[15:0];
        resWord1_q <= resAll[31:16];
        resWord2_q <= resAll[47:32];
        resWord3_q <= resAll[63:48];
        resCount_q <= words;
      end
    end
  end

  // Carry is updated only by multiplies that really execute
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      carry_flag <= 1'b0;
    end else if (fire && isMul && !rangeErr) begin
      carry_flag <= ovf;
    end
  end

  // Error flag is sticky; software elsewhere owns its clearing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      operation_error_flag <= 1'b0;
      error_code_reg <= `ERR_CODE_RESET;
    end else if (fire && rangeErr) begin
      operation_error_flag <= 1'b1;
      error_code_reg <= `ERR_CODE_RANGE;
    end else if (fire && zeroErr) begin
      operation_error_flag <= 1'b1;
      error_code_reg <= `ERR_CODE_DIV_ZERO;
    end
  end

  // Pulse mode never fires twice while enable stays high
  pulse_once_a: assert property (@(posedge clk) disable iff (!rst_n)
    pulseMode && enable && enableLast_q |=> !resWrite_q)
    else $error("pulse op executed without an enable edge");

  // Zero divisor yields error code and no write
  div_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    fire && zeroErr && !rangeErr |=> operation_error_flag &&
    error_code_reg == `ERR_CODE_DIV_ZERO && !resWrite_q)
    else $error("divide by zero not reported");

  // Range error yields range code and no write
  range_err_a: assert property (@(posedge clk) disable iff (!rst_n)
    fire && rangeErr |=> error_code_reg == `ERR_CODE_RANGE && !resWrite_q)
    else $error("range error not reported");

  // Carry untouched on a skipped operation
  carry_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    fire && (rangeErr || zeroErr) |=> $stable(carry_flag))
    else $error("carry changed by skipped op");

  // 16-bit decrement wraps most negative to most positive
  dec_wrap_a: assert property (@(posedge clk) disable iff (!rst_n)
    fire && !rangeErr && opSel == decrement_op && srcA[15:0] == 16'h8000
    |=> resWord0_q == 16'h7FFF)
    else $error("16-bit decrement wrap wrong");

  // 32-bit decrement wraps across the full range
  dec32_wrap_a: assert property (@(posedge clk) disable iff (!rst_n)
    fire && !rangeErr && opSel == decrement_op_32 && srcA == 32'h8000_0000
    |=> {resWord1_q, resWord0_q} == 32'h7FFF_FFFF)
    else $error("32-bit decrement wrap wrong");

  // 16-bit overflow sets carry
  mul_carry_a: assert property (@(posedge clk) disable iff (!rst_n)
    fire && !rangeErr && opSel == multiply_op_16 &&
    (srcA[15:0] == 16'h4000) && (srcB[15:0] == 16'h0004) |=> carry_flag &&
    resWord0_q == 16'h0000)
    else $error("16-bit multiply overflow missed");

  // 16-bit divide places remainder after quotient
  div_place_a: assert property (@(posedge clk) disable iff (!rst_n)
    fire && !rangeErr && opSel == divide_op_16 && srcA[15:0] == 16'h0007 &&
    srcB[15:0] == 16'h0002 |=> resWord0_q == 16'h0003 &&
    resWord1_q == 16'h0001 && resCount_q == 3'd2)
    else $error("16-bit divide placement wrong");
endmodule : signed_dec_mul_div_unit

// ==== verilog/arith_unit_params.svh ====
`ifndef ARITH_UNIT_PARAMS_SVH
`define ARITH_UNIT_PARAMS_SVH
// Error codes loaded into the error-code register
`define ERR_CODE_RANGE 16'h2003
`define ERR_CODE_DIV_ZERO 16'h2012
`define ERR_CODE_RESET 16'h0000
// Word width and most words written by one result
`define WORD_W 16
`define DEST_WORDS 4
// Default last valid word address (parameter default)
`define ADDR_W 16
`define ADDR_LAST 16'hFFFF
`endif

// ==== verilog/arith_unit_pkg.sv ====
package arith_unit_pkg;
  // Operation selected by the sequencer
  typedef enum logic [2:0] {
    decrement_op,
    decrement_op_32,
    multiply_op_16,
    multiply_op_32,
    divide_op_16,
    divide_op_32
  } op_t;
endpackage : arith_unit_pkg

// ==== verilog/signed_divider.sv ====
`timescale 1ns/100ps
`include "arith_unit_params.svh"
// Combinational signed divide, truncating toward zero
module signed_divider #(
  parameter int W = 32
) (
  // Operands
  input wire logic signed [W-1:0] dividend,
  input wire logic signed [W-1:0] divisor,
  // Results
  output logic signed [W-1:0] quotient,
  output logic signed [W-1:0] remainder
);
  // A zero divisor gives zero quotient and remainder; the caller flags that case itself
  always_comb begin
    if (divisor == '0) begin
      quotient = '0;
      remainder = '0;
    end else begin
      quotient = dividend / divisor;
      remainder = dividend % divisor;
    end
  end
endmodule : signed_divider

// ==== tb/op_sequencer.sv ====
`timescale 1ns/100ps
module op_sequencer
  import arith_unit_pkg::*;
(
  // Clock
  input wire logic clk,
  // Request to the unit
  output logic enable,
  output logic pulseMode,
  output op_t opSel,
  output logic [31:0] srcA,
  output logic [31:0] srcB,
  output logic [15:0] destAddr
);
  // Idle request at time zero
  initial begin
    enable = 1'b0;
    pulseMode = 1'b0;
    opSel = decrement_op;
    srcA = 32'h0;
    srcB = 32'h0;
    destAddr = 16'h0;
  end
  // Hold a request for cnt edges, then release it
  task automatic issue(input op_t op, input logic [31:0] a, b,
      input logic [15:0] d, input logic pm, input int cnt);
    logic wide;
    wide = op inside {decrement_op_32, multiply_op_32, divide_op_32};
    @(posedge clk);
    enable <= 1'b1;
    pulseMode <= pm;
    opSel <= op;
    srcA <= wide ? a : {16'h0, a[15:0]};
    srcB <= wide ? b : {16'h0, b[15:0]};
    destAddr <= d;
    repeat (cnt) @(posedge clk);
    enable <= 1'b0;
    // Stale operands must not look valid once released
    srcA <= ~srcA;
    srcB <= ~srcB;
  endtask : issue
endmodule : op_sequencer

// ==== tb/signed_dec_mul_div_unit_tb.sv ====
`timescale 1ns/100ps
`include "arith_unit_params.svh"
module signed_dec_mul_div_unit_tb import arith_unit_pkg::*; ();
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic enable, pulseMode, resWrite, carry, errFlag;
  op_t opSel;
  logic [31:0] srcA, srcB;
  logic [15:0] destAddr, errCode;
  logic [15:0] w [4];
  logic [15:0] ew [4];
  logic [2:0] resCount, en;
  logic expCarry, expErr;
  logic [15:0] expCode;
  int seed = 78871;
  int n_fail = 0;
  int total_checks = 0;
  int nWrites = 0;
  // Small top address so range refusals are cheap to reach
  localparam logic [15:0] LAST = 16'h1000;

  always #5 clk = ~clk;

  op_sequencer seq (.clk(clk), .enable(enable), .pulseMode(pulseMode),
    .opSel(opSel), .srcA(srcA), .srcB(srcB), .destAddr(destAddr));

  signed_dec_mul_div_unit #(.LAST_ADDR(LAST)) dut (.clk(clk), .rst_n(rst_n),
    .enable(enable), .pulseMode(pulseMode), .opSel(opSel), .srcA(srcA),
    .srcB(srcB), .destAddr(destAddr), .resWord0_q(w[0]), .resWord1_q(w[1]),
    .resWord2_q(w[2]), .resWord3_q(w[3]), .resCount_q(resCount),
    .resWrite_q(resWrite), .carry_flag(carry),
    .operation_error_flag(errFlag), .error_code_reg(errCode));

  // Count executed operations for the edge-trigger tests
  always @(posedge clk) if (resWrite === 1'b1) nWrites <= nWrites + 1;

  task automatic chk(input string name, input logic [31:0] seen, expv);
    total_checks++;
    if (seen !== expv) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, expv, seen);
    end
  endtask : chk

  task automatic results;
    $display("Checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results

  // Work out the expected answer, issue the op, compare one cycle later
  task automatic run(input op_t op, input logic [31:0] a, b,
      input logic [15:0] d);
    logic [63:0] p;
    logic [31:0] q, r;
    logic [15:0] x [4];
    logic [2:0] n;
    logic c, bad;
    c = expCarry;
    bad = 1'b0;
    n = (op == divide_op_32) ? 3'd4 : (op inside {decrement_op,
      multiply_op_16}) ? 3'd1 : 3'd2;
    case (op)
      decrement_op: x[0] = a[15:0] - 16'h1;
      decrement_op_32: {x[1], x[0]} = a - 32'h1;
      multiply_op_16: begin
        p = $signed(a[15:0]) * $signed(b[15:0]);
        x[0] = p[15:0];
        c = $signed(p) != $signed(p[15:0]);
      end
      multiply_op_32: begin
        p = $signed(a) * $signed(b);
        {x[1], x[0]} = p[31:0];
        c = $signed(p) != $signed(p[31:0]);
      end
      divide_op_16: begin
        bad = b[15:0] == 16'h0;
        q = $signed(a[15:0]) / $signed(b[15:0]);
        r = $signed(a[15:0]) % $signed(b[15:0]);
        {x[1], x[0]} = {r[15:0], q[15:0]};
      end
      default: begin
        bad = b == 32'h0;
        q = $signed(a) / $signed(b);
        r = $signed(a) % $signed(b);
        {x[3], x[2], x[1], x[0]} = {r, q};
      end
    endcase
    if (bad) expCode = `ERR_CODE_DIV_ZERO;
    if (32'(d) + 32'(n) - 1 > 32'(LAST)) begin
      bad = 1'b1;
      expCode = `ERR_CODE_RANGE;
    end
    expErr = expErr | bad;
    if (!bad) begin
      expCarry = c;
      en = n;
      for (int i = 0; i < 4; i++) ew[i] = x[i];
    end
    seq.issue(op, a, b, d, 1'b0, 1);
    #1;
    chk("write", resWrite, !bad);
    chk("carry", carry, expCarry);
    chk("error", errFlag, expErr);
    chk("code", errCode, expCode);
    chk("count", resCount, en);
    for (int i = 0; i < 4; i++) begin
      if (i < en) chk("word", w[i], ew[i]);
    end
  endtask : run

  task automatic pulses(input logic pm, input int expN);
    int n0;
    n0 = nWrites;
    seq.issue(decrement_op_32, 32'h5, 32'h0, 16'h10, pm, 3);
    repeat (2) @(posedge clk);
    #1;
    chk("writes", nWrites - n0, expN);
    en = 3'd2;
    {ew[1], ew[0]} = 32'h4;
  endtask : pulses

  // Watchdog sized well beyond the expected run
  initial begin
    #40000;
    n_fail++;
    results();
  end

  initial begin
    {expCarry, expErr, expCode, en} = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk("reset", {carry, errFlag, errCode, resWrite}, 32'h0);
    chk("rstword", {resCount, w[1], w[0]}, 32'h0);
    run(decrement_op, 32'h8000, 0, 16'h0);
    run(decrement_op_32, 32'h80000000, 0, 16'h0FFF);
    run(multiply_op_16, 32'd300, 32'd300, 16'h20);
    run(multiply_op_16, 32'hFFFD, 32'd5, 16'h20);
    run(multiply_op_16, 32'h4000, 32'h4, 16'h20);
    run(divide_op_16, 32'd7, 32'd2, 16'h20);
    run(multiply_op_32, 32'h10000, 32'h10000, 16'h20);
    run(divide_op_16, 32'hFFF9, 32'd2, 16'h20);
    run(divide_op_32, -32'sd100000, 32'd7, 16'h0FFD);
    run(divide_op_16, 32'd9, 32'd0, 16'h20);
    run(divide_op_32, 32'd9, 32'd3, 16'h0FFE);
    run(divide_op_16, 32'd9, 32'd0, LAST);
    $display("corner cases done");
    pulses(1'b0, 3);
    pulses(1'b1, 1);
    $display("edge trigger done");
    repeat (80) run(op_t'($unsigned($random(seed)) % 6), $random(seed),
      $random(seed), 16'($unsigned($random(seed)) % 32'h0F00));
    $display("random ops done");
    results();
  end
endmodule : signed_dec_mul_div_unit_tb
